// >>> cscc_acc_sat.sv
`timescale 1ns/10ps
`include "cscc_defs.svh"
// one accumulator: guard overflow detect and saturation
module cscc_acc_sat
   import cscc_pkg::*;
(
   input wire logic [39:0] accIn,
   input wire logic satEnable,
   input wire logic satSuper,
   output logic [39:0] accOut,
   output logic guardOverflow,
   output logic satEvent
);
   logic over31;
   logic neg;
   // guard bits 39..32 not identical means recoverable overflow
   assign guardOverflow = !((&accIn[39:32]) || !(|accIn[39:32]));
   // bits 39..31 not identical means the 1.31 range is exceeded
   assign over31 = !((&accIn[39:31]) || !(|accIn[39:31]));
   assign neg = accIn[39];
   // saturate to 1.31 limits in normal mode only, super mode passes the sum through
   always_comb
   begin
      accOut = accIn;
      satEvent = 1'b0;
      if (satEnable && !satSuper && over31)
      begin
         accOut = neg ? 40'hFF80000000 : 40'h007FFFFFFF;
         satEvent = 1'b1;
      end
   end
endmodule // cscc_acc_sat

// >>> cscc_defs.svh
`ifndef CSCC_DEFS_SVH
`define CSCC_DEFS_SVH
// register byte addresses on the bus
`define CSCC_STATUS_ADDR 8'h00
`define CSCC_CORE_ADDR 8'h04
`define CSCC_PAGE_ADDR 8'h08
`define CSCC_PRIO_ADDR 8'h0C
// status word bit positions
`define CSCC_C_BIT 0
`define CSCC_Z_BIT 1
`define CSCC_OV_BIT 2
`define CSCC_N_BIT 3
`define CSCC_RPT_BIT 4
`define CSCC_IPL_LO 5
`define CSCC_IPL_HI 7
`define CSCC_DC_BIT 8
`define CSCC_LOOP_BIT 9
`define CSCC_SAB_BIT 10
`define CSCC_OAB_BIT 11
`define CSCC_SB_BIT 12
`define CSCC_SA_BIT 13
`define CSCC_OB_BIT 14
`define CSCC_OA_BIT 15
// core control bit positions
`define CSCC_IF_BIT 0
`define CSCC_RND_BIT 1
`define CSCC_PSV_BIT 2
`define CSCC_CPU_PRIORITY_TOP_BIT_BIT 3
`define CSCC_SAT_MODE_SELECT_BIT 4
`define CSCC_MEM_WRITE_SAT_ENABLE_BIT 5
`define CSCC_ACC_B_SAT_ENABLE_BIT 6
`define CSCC_ACC_A_SAT_ENABLE_BIT 7
`define CSCC_DL_LO 8
`define CSCC_DL_HI 10
`define CSCC_EDT_BIT 11
`define CSCC_US_BIT 12
// reset values
`define CSCC_STATUS_RST 16'h0000
`define CSCC_CORE_RST 16'h0020
`define CSCC_PAGE_RST 8'h00
// divide length in instruction cycles
`define CSCC_DIV_CYCLES 5'h13
// data window base in data space
`define CSCC_WIN_BASE 16'h8000
`endif

// >>> cscc_divider.sv
`timescale 1ns/10ps
`include "cscc_defs.svh"
// iterative divide step counter, holds state across interrupts
module cscc_divider
   import cscc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic divStep,
   input wire logic divStart,
   output logic divDone,
   output logic [4:0] divCount
);
   logic [4:0] count_ff;
   // counter only advances on an executed step, so stalls keep it
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         count_ff <= 5'h00;
      else if (divStart)
         count_ff <= 5'h00;
      else if (divStep && count_ff != `CSCC_DIV_CYCLES)
         count_ff <= count_ff + 5'h01;
   end
   assign divCount = count_ff;
   assign divDone = (count_ff == `CSCC_DIV_CYCLES);
endmodule // cscc_divider

// >>> cscc_pkg.sv
package cscc_pkg;
   typedef enum logic [1:0] {CSCC_ADD, CSCC_SUB, CSCC_LOGIC} cscc_alu_op_type;
   typedef enum {CSCC_ACC_IDLE, CSCC_ACC_RUN} cscc_acc_state_type;
endpackage

// >>> cscc_status_core.sv
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "cscc_defs.svh"
module cscc_status_core
   import cscc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hsel,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic aluValid,
   input wire logic [1:0] aluOp,
   input wire logic aluByte,
   input wire logic [15:0] aluA,
   input wire logic [15:0] aluB,
   input wire logic accValid,
   input wire logic accSelB,
   input wire logic [39:0] accSum,
   input wire logic repeatActive,
   input wire logic loopStart,
   input wire logic loopEnd,
   input wire logic nestingDisable,
   input wire logic divStep,
   input wire logic divStart,
   input wire logic trapEntry,
   input wire logic [15:0] dataAddr,
   output logic [39:0] accResult,
   output logic [15:0] aluResult,
   output logic [3:0] cpuPriority,
   output logic userIntDisable,
   output logic loopTerminate,
   output logic progWindowHit,
   output logic [22:0] progAddr,
   output logic divDone,
   output logic mulInteger,
   output logic mulUnsigned,
   output logic roundConventional,
   output logic memWriteSat
);
   cscc_alu_op_type op;
   logic carryFlag_ff, zeroFlag_ff, negFlag_ff, wrapFlag_ff, halfFlag_ff;
   logic accAOver_ff, accBOver_ff, accASat_ff, accBSat_ff;
   logic [2:0] priLow_ff;
   logic priTop_ff, progWinEn_ff, roundSel_ff, intMode_ff, signSel_ff;
   logic accASatEn_ff, accBSatEn_ff, memSatEn_ff, satMode_ff;
   logic [2:0] loopDepth_ff;
   logic [7:0] progPage_ff;
   logic rptSync1_ff, rptSync_ff, nstSync1_ff, nstSync_ff;
   logic wrPend_ff;
   logic [7:0] wrAddr_ff;
   logic [31:0] hrdata_ff;
   logic [39:0] accResult_ff;
   logic [15:0] aluResult_ff;
   logic [3:0] cpuPriority_ff;
   logic userIntDis_ff, loopTerm_ff, progHit_ff, divDone_ff;
   logic [22:0] progAddr_ff;
   logic [16:0] sum;
   logic [15:0] res;
   logic resNeg, resZero, cOut, hOut, ovOut;
   logic [4:0] nibSum;
   logic [8:0] byteSum;
   logic [39:0] sat_mode_select;
   logic guardOv, satEv, divDoneW;
   logic [15:0] statusWord, coreWord;
   logic busWrite, wrStatus, wrCore, wrPage;
   logic accASet, accBSet;

   assign op = cscc_alu_op_type'(aluOp);

   // alu result with byte or word flag sources
   always_comb
   begin
      sum = 17'h00000;
      res = 16'h0000;
      nibSum = 5'h00;
      byteSum = 9'h000;
      unique case (op)
         CSCC_ADD:
         begin
            sum = {1'b0, aluA} + {1'b0, aluB};
            nibSum = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]};
            byteSum = {1'b0, aluA[7:0]} + {1'b0, aluB[7:0]};
         end
         CSCC_SUB:
         begin
            sum = {1'b0, aluA} + {1'b0, ~aluB} + 17'h00001;
            nibSum = {1'b0, aluA[3:0]} + {1'b0, ~aluB[3:0]} + 5'h01;
            byteSum = {1'b0, aluA[7:0]} + {1'b0, ~aluB[7:0]} + 9'h001;
         end
         default: sum = {1'b0, aluA & aluB};
      endcase
      res = sum[15:0];
   end
   assign resNeg = aluByte ? res[7] : res[15];
   assign resZero = aluByte ? (res[7:0] == 8'h00) : (res == 16'h0000);
   assign cOut = aluByte ? byteSum[8] : sum[16];
   assign hOut = aluByte ? nibSum[4] : byteSum[8];
   assign ovOut = aluByte
      ? ((aluA[7] == (op == CSCC_SUB ? ~aluB[7] : aluB[7])) && (res[7] != aluA[7]))
      : ((aluA[15] == (op == CSCC_SUB ? ~aluB[15] : aluB[15])) && (res[15] != aluA[15]));

   // accumulator saturation block
   cscc_acc_sat accSatUnit (
      .accIn(accSum),
      .satEnable(accSelB ? accBSatEn_ff : accASatEn_ff),
      .satSuper(satMode_ff),
      .accOut(sat_mode_select),
      .guardOverflow(guardOv),
      .satEvent(satEv)
   );

   // divide step tracking
   cscc_divider divUnit (
      .clock(clock),
      .reset(reset),
      .divStep(divStep),
      .divStart(divStart),
      .divDone(divDoneW),
      .divCount()
   );

   // pin synchronisers
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rptSync1_ff <= 1'b0;
         rptSync_ff <= 1'b0;
         nstSync1_ff <= 1'b0;
         nstSync_ff <= 1'b0;
      end
      else
      begin
         rptSync1_ff <= repeatActive;
         rptSync_ff <= rptSync1_ff;
         nstSync1_ff <= nestingDisable;
         nstSync_ff <= nstSync1_ff;
      end
   end

   // ahb address phase capture
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         wrPend_ff <= 1'b0;
         wrAddr_ff <= 8'h00;
      end
      else if (hready)
      begin
         wrPend_ff <= hsel && htrans[1] && hwrite;
         wrAddr_ff <= haddr;
      end
   end
   assign busWrite = wrPend_ff;
   assign wrStatus = busWrite && wrAddr_ff == `CSCC_STATUS_ADDR;
   assign wrCore = busWrite && wrAddr_ff == `CSCC_CORE_ADDR;
   assign wrPage = busWrite && wrAddr_ff == `CSCC_PAGE_ADDR;
   assign accASet = accValid && !accSelB && satEv;
   assign accBSet = accValid && accSelB && satEv;

   // mcu alu flags, hardware update wins over software write
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         carryFlag_ff <= 1'b0;
         zeroFlag_ff <= 1'b0;
         negFlag_ff <= 1'b0;
         wrapFlag_ff <= 1'b0;
         halfFlag_ff <= 1'b0;
      end
      else if (aluValid)
      begin
         carryFlag_ff <= cOut;
         zeroFlag_ff <= resZero;
         negFlag_ff <= resNeg;
         wrapFlag_ff <= (op == CSCC_LOGIC) ? 1'b0 : ovOut;
         halfFlag_ff <= hOut;
      end
      else if (wrStatus)
      begin
         carryFlag_ff <= hwdata[`CSCC_C_BIT];
         zeroFlag_ff <= hwdata[`CSCC_Z_BIT];
         negFlag_ff <= hwdata[`CSCC_N_BIT];
         wrapFlag_ff <= hwdata[`CSCC_OV_BIT];
         halfFlag_ff <= hwdata[`CSCC_DC_BIT];
      end
   end

   // accumulator overflow and sticky saturation flags
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         accAOver_ff <= 1'b0;
         accBOver_ff <= 1'b0;
         accASat_ff <= 1'b0;
         accBSat_ff <= 1'b0;
      end
      else
      begin
         if (accValid && !accSelB)
            accAOver_ff <= guardOv;
         if (accValid && accSelB)
            accBOver_ff <= guardOv;
         if (accASet)
            accASat_ff <= 1'b1;
         else if (wrStatus && (!hwdata[`CSCC_SA_BIT] || !hwdata[`CSCC_SAB_BIT]))
            accASat_ff <= 1'b0;
         if (accBSet)
            accBSat_ff <= 1'b1;
         else if (wrStatus && (!hwdata[`CSCC_SB_BIT] || !hwdata[`CSCC_SAB_BIT]))
            accBSat_ff <= 1'b0;
      end
   end

   // priority bits, locked while nesting disabled
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         priLow_ff <= 3'h0;
      else if (wrStatus && !nstSync_ff)
         priLow_ff <= hwdata[`CSCC_IPL_HI:`CSCC_IPL_LO];
   end

   // core control fields
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         intMode_ff <= 1'b0;
         roundSel_ff <= 1'b0;
         progWinEn_ff <= 1'b0;
         satMode_ff <= 1'b0;
         memSatEn_ff <= 1'b1;
         accBSatEn_ff <= 1'b0;
         accASatEn_ff <= 1'b0;
         signSel_ff <= 1'b0;
      end
      else if (wrCore)
      begin
         intMode_ff <= hwdata[`CSCC_IF_BIT];
         roundSel_ff <= hwdata[`CSCC_RND_BIT];
         progWinEn_ff <= hwdata[`CSCC_PSV_BIT];
         satMode_ff <= hwdata[`CSCC_SAT_MODE_SELECT_BIT];
         memSatEn_ff <= hwdata[`CSCC_MEM_WRITE_SAT_ENABLE_BIT];
         accBSatEn_ff <= hwdata[`CSCC_ACC_B_SAT_ENABLE_BIT];
         accASatEn_ff <= hwdata[`CSCC_ACC_A_SAT_ENABLE_BIT];
         signSel_ff <= hwdata[`CSCC_US_BIT];
      end
   end

   // priority top bit: trap entry raises it, software may only clear it
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         priTop_ff <= 1'b0;
      else if (trapEntry)
         priTop_ff <= 1'b1;
      else if (wrCore && !hwdata[`CSCC_CPU_PRIORITY_TOP_BIT_BIT])
         priTop_ff <= 1'b0;
   end

   // block loop nesting depth
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         loopDepth_ff <= 3'h0;
      else if (loopStart && !loopEnd && loopDepth_ff != 3'h7)
         loopDepth_ff <= loopDepth_ff + 3'h1;
      else if (loopEnd && !loopStart && loopDepth_ff != 3'h0)
         loopDepth_ff <= loopDepth_ff - 3'h1;
   end

   // program window page
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         progPage_ff <= `CSCC_PAGE_RST;
      else if (wrPage)
         progPage_ff <= hwdata[7:0];
   end

   // read views of both words
   assign statusWord = {accAOver_ff, accBOver_ff, accASat_ff, accBSat_ff,
      accAOver_ff | accBOver_ff, accASat_ff | accBSat_ff,
      loopDepth_ff != 3'h0, halfFlag_ff, priLow_ff, rptSync_ff,
      negFlag_ff, wrapFlag_ff, zeroFlag_ff, carryFlag_ff};
   assign coreWord = {3'h0, signSel_ff, 1'b0, loopDepth_ff, accASatEn_ff,
      accBSatEn_ff, memSatEn_ff, satMode_ff, priTop_ff, progWinEn_ff,
      roundSel_ff, intMode_ff};

   // bus read data, zero for unmapped addresses
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         hrdata_ff <= 32'h00000000;
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         unique case (haddr)
            `CSCC_STATUS_ADDR: hrdata_ff <= {16'h0000, statusWord};
            `CSCC_CORE_ADDR: hrdata_ff <= {16'h0000, coreWord};
            `CSCC_PAGE_ADDR: hrdata_ff <= {24'h000000, progPage_ff};
            `CSCC_PRIO_ADDR: hrdata_ff <= {28'h0000000, priTop_ff, priLow_ff};
            default: hrdata_ff <= 32'h00000000;
         endcase
      end
   end

   // registered block outputs
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         accResult_ff <= 40'h0000000000;
         aluResult_ff <= 16'h0000;
         cpuPriority_ff <= 4'h0;
         userIntDis_ff <= 1'b0;
         loopTerm_ff <= 1'b0;
         progHit_ff <= 1'b0;
         progAddr_ff <= 23'h000000;
         divDone_ff <= 1'b0;
      end
      else
      begin
         accResult_ff <= sat_mode_select;
         aluResult_ff <= res;
         cpuPriority_ff <= {priTop_ff, priLow_ff};
         userIntDis_ff <= priTop_ff || priLow_ff == 3'h7;
         loopTerm_ff <= wrCore && hwdata[`CSCC_EDT_BIT];
         progHit_ff <= progWinEn_ff && dataAddr[15];
         progAddr_ff <= {progPage_ff, dataAddr[14:0]};
         divDone_ff <= divDoneW;
      end
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign accResult = accResult_ff;
   assign aluResult = aluResult_ff;
   assign cpuPriority = cpuPriority_ff;
   assign userIntDisable = userIntDis_ff;
   assign loopTerminate = loopTerm_ff;
   assign progWindowHit = progHit_ff;
   assign progAddr = progAddr_ff;
   assign divDone = divDone_ff;
   assign mulInteger = intMode_ff;
   assign mulUnsigned = signSel_ff;
   assign roundConventional = roundSel_ff;
   assign memWriteSat = memSatEn_ff;

   a_sticky_hold: assert property (@(posedge clock) disable iff (reset)
      accASat_ff && !wrStatus |=> accASat_ff) else $error("sticky A lost");
   a_sat_sets: assert property (@(posedge clock) disable iff (reset)
      accBSet |=> accBSat_ff) else $error("sticky B not set");
   a_zero_flag: assert property (@(posedge clock) disable iff (reset)
      aluValid |=> zeroFlag_ff == $past(resZero)) else $error("zero wrong");
   a_carry_flag: assert property (@(posedge clock) disable iff (reset)
      aluValid |=> carryFlag_ff == $past(cOut)) else $error("carry wrong");
   a_prio_lock: assert property (@(posedge clock) disable iff (reset)
      nstSync_ff |=> $stable(priLow_ff)) else $error("priority changed");
   a_edt_zero: assert property (@(posedge clock) disable iff (reset)
      coreWord[`CSCC_EDT_BIT] == 1'b0) else $error("terminate bit reads one");
   a_prio_out: assert property (@(posedge clock) disable iff (reset)
      priTop_ff |=> userIntDis_ff) else $error("interrupts not disabled");
   a_combined_or: assert property (@(posedge clock) disable iff (reset)
      statusWord[`CSCC_OAB_BIT] == (accAOver_ff | accBOver_ff)) else $error("or wrong");
endmodule // cscc_status_core

// >>> tb_cpu_status_core_control.sv
`timescale 1ns/10ps
`include "cscc_defs.svh"
module tb_cpu_status_core_control
   import cscc_pkg::*;
;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp;
   logic aluValid = 1'b0, aluByte = 1'b0, accValid = 1'b0, accSelB = 1'b0;
   logic [1:0] aluOp = 2'h0;
   logic [15:0] aluA = 16'h0, aluB = 16'h0, dataAddr = 16'h0;
   logic [39:0] accSum = 40'h0;
   logic repeatActive = 1'b0, loopStart = 1'b0, loopEnd = 1'b0, nestingDisable = 1'b0;
   logic divStep = 1'b0, divStart = 1'b0;
   logic trapEntry = 1'b0;
   logic [39:0] accResult;
   logic [15:0] aluResult;
   logic [3:0] cpuPriority;
   logic userIntDisable, loopTerminate, progWindowHit, divDone;
   logic mulInteger, mulUnsigned, roundConventional, memWriteSat;
   logic [22:0] progAddr;
   logic [31:0] q;
   int errTotal = 0;
   int checksDone = 0;
   // device under test, bus ready looped back
   cscc_status_core i_cscc_status_core (.clock(clock), .reset(reset), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .aluValid(aluValid), .aluOp(aluOp), .aluByte(aluByte), .aluA(aluA), .aluB(aluB),
      .accValid(accValid), .accSelB(accSelB), .accSum(accSum), .repeatActive(repeatActive),
      .loopStart(loopStart), .loopEnd(loopEnd), .nestingDisable(nestingDisable),
      .divStep(divStep), .divStart(divStart), .trapEntry(trapEntry), .dataAddr(dataAddr),
      .accResult(accResult),
      .aluResult(aluResult), .cpuPriority(cpuPriority), .userIntDisable(userIntDisable),
      .loopTerminate(loopTerminate), .progWindowHit(progWindowHit), .progAddr(progAddr),
      .divDone(divDone), .mulInteger(mulInteger), .mulUnsigned(mulUnsigned),
      .roundConventional(roundConventional), .memWriteSat(memWriteSat));
   // clock generator
   always #5 clock = ~clock;
   // compare and count
   task chk(input logic [39:0] got, input logic [39:0] exp);
      checksDone++;
      if (got !== exp)
      begin
         errTotal++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // one single transfer, address then data phase
   task bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
      @(posedge clock);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      q = hrdata;
   endtask
   task alu(input logic [1:0] op, input logic bt, input logic [15:0] a, input logic [15:0] b);
      @(posedge clock);
      aluValid <= 1'b1;
      aluOp <= op;
      aluByte <= bt;
      aluA <= a;
      aluB <= b;
      @(posedge clock);
      aluValid <= 1'b0;
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
   endtask
   task acc(input logic selB, input logic [39:0] s);
      @(posedge clock);
      accValid <= 1'b1;
      accSelB <= selB;
      accSum <= s;
      @(posedge clock);
      accValid <= 1'b0;
      @(posedge clock);
   endtask
   // one-cycle strobes: bit 0 loop start, 1 loop end, 2 div start, 3 div step, 4 trap
   task pulse(input logic [4:0] sel);
      @(posedge clock);
      {trapEntry, divStep, divStart, loopEnd, loopStart} <= sel;
      @(posedge clock);
      {trapEntry, divStep, divStart, loopEnd, loopStart} <= 5'h00;
   endtask
   // reset values and unmapped place
   task t_reset;
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q, `CSCC_STATUS_RST);
      bus(`CSCC_CORE_ADDR, 1'b0, 32'h0);
      chk(q, `CSCC_CORE_RST);
      chk(memWriteSat, 1'b1);
      chk(hresp, 1'b0);
      bus(8'h10, 1'b0, 32'h0);
      chk(q, 32'h0);
      $display("test reset done");
   endtask
   // arithmetic flags
   task t_flags;
      alu(2'h0, 1'b0, 16'h7FFF, 16'h0001);
      chk(q[15:0] & 16'h010F, 16'h010C);
      chk(aluResult, 16'h8000);
      alu(2'h0, 1'b0, 16'hFFFF, 16'h0001);
      chk(q[15:0] & 16'h010F, 16'h0103);
      alu(2'h1, 1'b0, 16'h0005, 16'h0003);
      chk(q[15:0] & 16'h000E, 16'h0000);
      alu(2'h0, 1'b1, 16'h000F, 16'h0001);
      chk(q[8], 1'b1);
      alu(2'h0, 1'b0, 16'h000F, 16'h0001);
      chk(q[8], 1'b0);
      alu(2'h2, 1'b0, 16'h8000, 16'h8000);
      chk(q[15:0] & 16'h010F, 16'h0008);
      $display("test flags done");
   endtask
   // accumulator overflow and sticky saturation
   task t_sat;
      bus(`CSCC_CORE_ADDR, 1'b1, 32'h00A0);
      acc(1'b0, 40'h0080000000);
      chk(accResult, 40'h007FFFFFFF);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q[15:10], 6'h09);
      acc(1'b0, 40'h0100000000);
      chk(accResult, 40'h007FFFFFFF);
      acc(1'b1, 40'h0100000000);
      chk(accResult, 40'h0100000000);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q[15:10], 6'h3B);
      acc(1'b0, 40'h0000000010);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q[15:13], 3'h3);
      bus(`CSCC_STATUS_ADDR, 1'b1, 32'h3000);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q[13:12], 2'h0);
      chk(q[11:10], 2'h2);
      bus(`CSCC_STATUS_ADDR, 1'b1, 32'h3400);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk({q[13:12], q[10]}, 3'h0);
      bus(`CSCC_CORE_ADDR, 1'b1, 32'h0060);
      acc(1'b1, 40'hFF00000000);
      chk(accResult, 40'hFF80000000);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q[12], 1'b1);
      bus(`CSCC_STATUS_ADDR, 1'b1, 32'h0400);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q[12], 1'b0);
      bus(`CSCC_CORE_ADDR, 1'b1, 32'h0090);
      acc(1'b0, 40'h0100000000);
      chk(accResult, 40'h0100000000);
      $display("test saturation done");
   endtask
   // priority level, nesting lock and trap raised top bit
   task t_prio;
      bus(`CSCC_STATUS_ADDR, 1'b1, 32'h00E0);
      tick(2);
      chk(cpuPriority, 4'h7);
      chk(userIntDisable, 1'b1);
      nestingDisable <= 1'b1;
      tick(4);
      bus(`CSCC_STATUS_ADDR, 1'b1, 32'h0040);
      tick(2);
      chk(cpuPriority, 4'h7);
      nestingDisable <= 1'b0;
      tick(4);
      bus(`CSCC_STATUS_ADDR, 1'b1, 32'h0040);
      bus(`CSCC_PRIO_ADDR, 1'b0, 32'h0);
      chk(q, 32'h2);
      chk(userIntDisable, 1'b0);
      pulse(5'h10);
      tick(2);
      chk(cpuPriority, 4'hA);
      chk(userIntDisable, 1'b1);
      bus(`CSCC_CORE_ADDR, 1'b1, 32'h0008);
      bus(`CSCC_PRIO_ADDR, 1'b0, 32'h0);
      chk(q, 32'hA);
      bus(`CSCC_CORE_ADDR, 1'b1, 32'h0000);
      bus(`CSCC_PRIO_ADDR, 1'b0, 32'h0);
      chk(q, 32'h2);
      $display("test priority done");
   endtask
   // mode bits and program window
   task t_modes;
      bus(`CSCC_CORE_ADDR, 1'b1, 32'h1007);
      bus(`CSCC_CORE_ADDR, 1'b0, 32'h0);
      chk(q, 32'h1007);
      chk({mulUnsigned, roundConventional, mulInteger, memWriteSat}, 4'hE);
      bus(`CSCC_PAGE_ADDR, 1'b1, 32'h5A);
      dataAddr <= 16'hC123;
      tick(2);
      chk(progWindowHit, 1'b1);
      chk(progAddr, {8'h5A, 15'h4123});
      dataAddr <= 16'h4123;
      tick(2);
      chk(progWindowHit, 1'b0);
      $display("test modes done");
   endtask
   // repeat and block loop status
   task t_loops;
      int seen;
      seen = 0;
      repeatActive <= 1'b1;
      tick(4);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q[4], 1'b1);
      repeatActive <= 1'b0;
      tick(4);
      bus(`CSCC_STATUS_ADDR, 1'b1, 32'h0010);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q[4], 1'b0);
      pulse(5'h01);
      bus(`CSCC_CORE_ADDR, 1'b1, 32'h0F07);
      repeat (4)
      begin
         @(posedge clock);
         if (loopTerminate === 1'b1) seen++;
      end
      chk(seen, 1);
      bus(`CSCC_CORE_ADDR, 1'b0, 32'h0);
      chk(q[11:8], 4'h1);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q[9], 1'b1);
      pulse(5'h02);
      bus(`CSCC_STATUS_ADDR, 1'b0, 32'h0);
      chk(q[9], 1'b0);
      $display("test loops done");
   endtask
   // divide interrupted midway
   task t_div;
      pulse(5'h04);
      repeat (9) pulse(5'h08);
      tick(6);
      repeat (9) pulse(5'h08);
      tick(2);
      chk(divDone, 1'b0);
      pulse(5'h08);
      tick(2);
      chk(divDone, 1'b1);
      $display("test divide done");
   endtask
   task complete_run;
      $display("checks=%0d mismatches=%0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog
   initial
   begin
      #200000;
      errTotal++;
      complete_run();
   end
   // main sequence
   initial
   begin
      tick(12);
      reset <= 1'b0;
      t_reset();
      t_flags();
      t_sat();
      t_prio();
      t_modes();
      t_loops();
      t_div();
      complete_run();
   end
endmodule // tb_cpu_status_core_control
